// file: core/hbm_defs.svh
// Constants for the handshake bus cycle master: widths, reset levels, sync bit map.
// Assumes the includer sits on the single 40 MHz core clock, one bus half-state per edge.
// Behaviour
// - Address strobe marks every cycle; strobes qualify write data
// - No wait limit; add whole-clock waits until acknowledge
// - Write drives read/write low with address strobe
// - Write data valid before data strobes assert
// - Four clocks, eight half states, whole-clock waits
// - S0 drives function code, read/write high
// - S1 drives the slave address
// - S2 asserts address strobe; read strobes, write low
// - S3 drives write data; read unchanged
// - S4 asserts write data strobes; read unchanged
// - Ignore responses before the end of S4
// - Acknowledge or fault at S4 end advances S5
// - No termination keeps S4 with wait states
// - S7 latches read data, negates strobes
// - Fault without halt ends cycle, raises exception
// - Fault with halt ends cycle, reruns after halt
`ifndef HBM_DEFS_SVH
`define HBM_DEFS_SVH
`define HBM_ADDR_W 24
`define HBM_DATA_W 16
`define HBM_FC_W 3
`define HBM_SYNC_IN_W 3
`define HBM_SYNC_IDLE 3'h7
`define HBM_SYNC_ACK 0
`define HBM_SYNC_FAULT 1
`define HBM_SYNC_HALT 2
`define HBM_LANE_BIT 0
`define HBM_ADDR_RST 24'h000000
`define HBM_DATA_RST 16'h0000
`define HBM_FC_RST 3'h0
`endif

// file: core/hbm_pkg.sv
// Types shared by the handshake bus cycle master modules.
// Assumes hbm_defs.svh supplies the widths.
`default_nettype none
package hbm_pkg;
    // One state per half bus clock; wait_lo pairs with s4 to form a whole wait clock
    typedef enum logic [3:0] {
        HBM_IDLE, HBM_S0, HBM_S1, HBM_S2, HBM_S3, HBM_S4, HBM_WAIT_LO,
        HBM_S5, HBM_S6, HBM_S7, HBM_HOLD
    } hbm_state_t;
    typedef enum logic [1:0] {
        HBM_END_NORMAL, HBM_END_FAULT, HBM_END_RETRY
    } hbm_end_t;
endpackage
`default_nettype wire

// file: core/hbm_sync.sv
// Two-flop synchroniser bank for the slave's response pins.
// Assumes inputs are asynchronous to clk_i; idle level set per bit.
`include "hbm_defs.svh"
`default_nettype none
module hbm_sync
    import hbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [`HBM_SYNC_IN_W-1:0] pin_i,
    output logic [`HBM_SYNC_IN_W-1:0] sync_o
);
    localparam logic [`HBM_SYNC_IN_W-1:0] idle_lvl = `HBM_SYNC_IDLE;
    genvar g;
    generate
        for (g = 0; g < `HBM_SYNC_IN_W; g++) begin : g_bit
            logic meta;
            logic next_meta;
            logic stable;
            logic next_stable;
            always_comb begin
                next_meta = pin_i[g];
                next_stable = meta;
                // Reset only the second flop, so no gate sits ahead of the first
                if (!rst_b_i) begin
                    next_stable = idle_lvl[g];
                end
            end
            always_ff @(posedge clk_i) begin
                meta <= next_meta;
                stable <= next_stable;
            end
            assign sync_o[g] = stable;
        end
    endgenerate
endmodule
`default_nettype wire

// file: core/hbm_lane.sv
// Byte-lane decode: picks the upper and lower data strobes for an access.
// Assumes the even byte sits on the upper lane.
`include "hbm_defs.svh"
`default_nettype none
module hbm_lane
    import hbm_pkg::*;
(
    input wire logic word_i,
    input wire logic [`HBM_ADDR_W-1:0] addr_i,
    output logic upper_en_o,
    output logic lower_en_o
);
    function automatic logic [1:0] lane_sel(input logic word, input logic odd);
        lane_sel = word ? 2'h3 : (odd ? 2'h1 : 2'h2);
    endfunction

    always_comb begin
        {upper_en_o, lower_en_o} = lane_sel(word_i, addr_i[`HBM_LANE_BIT]);
    end
endmodule
`default_nettype wire

// file: core/hbm_master.sv
// Bus cycle master: runs S0..S7 with whole-clock waits, strobes, fault and retry.
// Assumes clk_i is the processor clock doubled; each edge is one half bus state.
`include "hbm_defs.svh"
`default_nettype none
module hbm_master
    import hbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    // User request side
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_word_i,
    input wire logic [`HBM_ADDR_W-1:0] req_addr_i,
    input wire logic [`HBM_FC_W-1:0] req_fc_i,
    input wire logic [`HBM_DATA_W-1:0] req_wdata_i,
    output logic ready_o,
    output logic done_o,
    output logic fault_o,
    output logic [`HBM_DATA_W-1:0] rdata_o,
    // Bus pins
    output logic [`HBM_ADDR_W-1:0] addr_o,
    output logic addr_oe_o,
    output logic [`HBM_FC_W-1:0] fc_o,
    output logic read_write_o,
    output logic address_strobe_n_o,
    output logic upper_byte_strobe_n_o,
    output logic lower_byte_strobe_n_o,
    output logic [`HBM_DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [`HBM_DATA_W-1:0] data_i,
    input wire logic transfer_ack_n_i,
    input wire logic bus_fault_n_i,
    input wire logic halt_n_i
);
    hbm_state_t state;
    hbm_state_t next_state;
    hbm_end_t ending;
    hbm_end_t next_ending;
    logic wr;
    logic next_wr;
    logic word;
    logic next_word;
    logic [`HBM_ADDR_W-1:0] addr;
    logic [`HBM_ADDR_W-1:0] next_addr;
    logic [`HBM_FC_W-1:0] fc;
    logic [`HBM_FC_W-1:0] next_fc;
    logic [`HBM_DATA_W-1:0] wdata;
    logic [`HBM_DATA_W-1:0] next_wdata;
    logic [`HBM_DATA_W-1:0] rdata;
    logic [`HBM_DATA_W-1:0] next_rdata;
    logic [`HBM_DATA_W-1:0] data_meta;
    logic [`HBM_DATA_W-1:0] data_sync;
    logic [`HBM_SYNC_IN_W-1:0] resp;
    logic ack;
    logic flt;
    logic hlt;
    logic up_en;
    logic lo_en;
    logic done;
    logic next_done;
    logic fault;
    logic next_fault;
    // Registered pin drivers
    logic next_addr_oe;
    logic [`HBM_FC_W-1:0] next_fc_o;
    logic next_rw;
    logic next_as_n;
    logic next_uds_n;
    logic next_lds_n;
    logic next_data_oe;
    logic [`HBM_DATA_W-1:0] next_data_o;

    hbm_sync u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i({halt_n_i, bus_fault_n_i, transfer_ack_n_i}),
        .sync_o(resp)
    );

    hbm_lane u_lane (
        .word_i(word),
        .addr_i(addr),
        .upper_en_o(up_en),
        .lower_en_o(lo_en)
    );

    assign ack = !resp[`HBM_SYNC_ACK];
    assign flt = !resp[`HBM_SYNC_FAULT];
    assign hlt = !resp[`HBM_SYNC_HALT];

    // Read data also crosses two flops before it is latched
    always_ff @(posedge clk_i) begin
        data_meta <= data_i;
        data_sync <= data_meta;
    end

    // Sequencer
    always_comb begin
        next_state = state;
        next_ending = ending;
        next_wr = wr;
        next_word = word;
        next_addr = addr;
        next_fc = fc;
        next_wdata = wdata;
        next_rdata = rdata;
        next_done = 1'b0;
        next_fault = 1'b0;
        case (state)
            HBM_IDLE: begin
                if (req_i) begin
                    next_wr = req_write_i;
                    next_word = req_word_i;
                    next_addr = req_addr_i;
                    next_fc = req_fc_i;
                    next_wdata = req_wdata_i;
                    next_state = HBM_S0;
                end
            end
            HBM_S0: next_state = HBM_S1;
            HBM_S1: next_state = HBM_S2;
            HBM_S2: next_state = HBM_S3;
            HBM_S3: next_state = HBM_S4;
            HBM_S4: begin
                // Acknowledge and fault only count here, at the end of S4
                if (ack || flt) begin
                    next_state = HBM_S5;
                    next_ending = !flt ? HBM_END_NORMAL :
                        (hlt ? HBM_END_RETRY : HBM_END_FAULT);
                end else begin
                    next_state = HBM_WAIT_LO;
                end
            end
            HBM_WAIT_LO: next_state = HBM_S4;
            HBM_S5: next_state = HBM_S6;
            HBM_S6: begin
                next_state = HBM_S7;
                if (!wr) begin
                    next_rdata = data_sync;
                end
            end
            HBM_S7: begin
                if (ending == HBM_END_RETRY) begin
                    next_state = HBM_HOLD;
                end else begin
                    next_state = HBM_IDLE;
                    next_done = (ending == HBM_END_NORMAL);
                    next_fault = (ending == HBM_END_FAULT);
                end
            end
            HBM_HOLD: begin
                // Rerun the same cycle once halt is gone
                if (!hlt) begin
                    next_state = HBM_S0;
                end
            end
            default: next_state = HBM_IDLE;
        endcase
        if (!rst_b_i) begin
            next_state = HBM_IDLE;
            next_ending = HBM_END_NORMAL;
            next_wr = 1'b0;
            next_word = 1'b0;
            next_addr = `HBM_ADDR_RST;
            next_fc = `HBM_FC_RST;
            next_wdata = `HBM_DATA_RST;
            next_rdata = `HBM_DATA_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        state <= next_state;
        ending <= next_ending;
        wr <= next_wr;
        word <= next_word;
        addr <= next_addr;
        fc <= next_fc;
        wdata <= next_wdata;
        rdata <= next_rdata;
        done <= next_done;
        fault <= next_fault;
    end

    // Pin values follow the state being entered, so they change on that edge
    always_comb begin
        next_addr_oe = 1'b0;
        next_fc_o = fc;
        next_rw = 1'b1;
        next_as_n = 1'b1;
        next_uds_n = 1'b1;
        next_lds_n = 1'b1;
        next_data_oe = 1'b0;
        next_data_o = data_o;
        case (next_state)
            HBM_IDLE, HBM_HOLD, HBM_S0: begin
                next_fc_o = next_fc;
            end
            HBM_S1: begin
                next_addr_oe = 1'b1;
            end
            HBM_S2, HBM_S3, HBM_S4, HBM_WAIT_LO, HBM_S5, HBM_S6: begin
                next_addr_oe = 1'b1;
                next_as_n = 1'b0;
                next_rw = !wr;
                if (next_state != HBM_S2) begin
                    next_data_oe = wr;
                    next_data_o = wdata;
                end
                // Read strobes from S2, write strobes from S4 after data settles
                if (!wr || (next_state != HBM_S2 && next_state != HBM_S3)) begin
                    next_uds_n = !up_en;
                    next_lds_n = !lo_en;
                end
            end
            HBM_S7: begin
                next_addr_oe = 1'b1;
                next_rw = !wr;
                next_data_oe = wr;
            end
            default: next_addr_oe = 1'b0;
        endcase
        if (!rst_b_i) begin
            next_fc_o = `HBM_FC_RST;
            next_data_o = `HBM_DATA_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        addr_oe_o <= next_addr_oe;
        fc_o <= next_fc_o;
        read_write_o <= next_rw;
        address_strobe_n_o <= next_as_n;
        upper_byte_strobe_n_o <= next_uds_n;
        lower_byte_strobe_n_o <= next_lds_n;
        data_oe_o <= next_data_oe;
        data_o <= next_data_o;
    end

    assign addr_o = addr;
    assign ready_o = (state == HBM_IDLE);
    assign done_o = done;
    assign fault_o = fault;
    assign rdata_o = rdata;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence seq_start;
        state == HBM_IDLE && req_i;
    endsequence
    sequence seq_as_rise;
        address_strobe_n_o ##1 address_strobe_n_o ##1 !address_strobe_n_o;
    endsequence
    // Tail of a terminated cycle; fault with halt ends in hold, any other ending in idle
    sequence seq_tail;
        state == HBM_S5 ##1 state == HBM_S6 ##1 state == HBM_S7
            ##1 state inside {HBM_IDLE, HBM_HOLD};
    endsequence

    a_as_start: assert property (seq_start |=> seq_as_rise)
        else $error("address strobe not asserted in S2");
    a_cycle_len: assert property ($rose(state == HBM_S0) |-> ##4 state == HBM_S4)
        else $error("S0 to S4 is not four half states");
    a_cycle_tail: assert property (state == HBM_S4 && (ack || flt) |=> seq_tail)
        else $error("terminated cycle did not run S5 to S7");
    a_s0_outputs: assert property (state == HBM_S0 |-> fc_o == fc && read_write_o &&
        address_strobe_n_o)
        else $error("S0 outputs wrong");
    a_s1_address: assert property (state == HBM_S1 |-> addr_oe_o && address_strobe_n_o)
        else $error("address not driven alone in S1");
    a_s2_strobes: assert property (state == HBM_S2 |-> (wr ?
        (upper_byte_strobe_n_o && lower_byte_strobe_n_o && !read_write_o) :
        !(upper_byte_strobe_n_o && lower_byte_strobe_n_o)))
        else $error("S2 strobes or read/write wrong");
    a_s3_data: assert property (state == HBM_S3 && wr |-> data_oe_o &&
        data_o == wdata && upper_byte_strobe_n_o && lower_byte_strobe_n_o)
        else $error("write data not driven alone in S3");
    a_done_pulse: assert property (state == HBM_S7 && ending == HBM_END_NORMAL |=>
        done_o && !fault_o && ready_o)
        else $error("normal end without done pulse");
    a_write_rw: assert property (!address_strobe_n_o && wr |-> !read_write_o)
        else $error("write with read/write high under address strobe");
    a_data_first: assert property (wr &&
        $fell(upper_byte_strobe_n_o && lower_byte_strobe_n_o) |-> data_oe_o && $past(data_oe_o))
        else $error("write strobe before data on the bus");
    a_wait_hold: assert property (state == HBM_S4 && !ack && !flt |=>
        state == HBM_WAIT_LO ##1 state == HBM_S4)
        else $error("wait state not a whole clock");
    a_no_early: assert property (state inside {HBM_S1, HBM_S2, HBM_S3} |=>
        state != HBM_S5)
        else $error("cycle ended before S4");
    a_s7_negate: assert property (state == HBM_S7 |-> address_strobe_n_o &&
        upper_byte_strobe_n_o && lower_byte_strobe_n_o)
        else $error("strobes still asserted in S7");
    a_fault_exc: assert property (state == HBM_S4 && flt && !hlt |=> ##3 fault_o)
        else $error("fault without halt did not raise exception");
    a_retry_run: assert property (state == HBM_HOLD && !hlt |=> state == HBM_S0)
        else $error("retry did not rerun after halt release");
    a_lane_word: assert property (!address_strobe_n_o && !upper_byte_strobe_n_o && word
        |-> !lower_byte_strobe_n_o)
        else $error("word access missing a byte strobe");
endmodule
`default_nettype wire

// file: dv/hbm_slave_model.sv
// Synchronous memory slave with fault and retry control for the bus master.
// Assumes it sees the master's strobes directly and is set up per cycle by the bench.
`include "hbm_defs.svh"
`default_nettype none
module hbm_slave_model (
    input wire logic clk_i,
    input wire logic as_n_i,
    input wire logic ds_n_i,
    input wire logic read_write_i,
    input wire logic [`HBM_DATA_W-1:0] wdata_i,
    input wire logic [7:0] delay_i,
    input wire logic [1:0] mode_i,
    // Read word is fixed before the strobe, as a predecoding slave would
    input wire logic [`HBM_DATA_W-1:0] rdata_i,
    output logic [`HBM_DATA_W-1:0] data_o,
    output logic ack_n_o,
    output logic fault_n_o,
    output logic halt_n_o,
    output logic [`HBM_DATA_W-1:0] got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;
    int halt_cnt;
    logic retried;
    initial begin
        {ack_n_o, fault_n_o, halt_n_o} = 3'h7;
        {data_o, got_o} = '0;
        {wait_cnt, halt_cnt, retried} = '0;
    end
    always @(posedge clk_i) begin
        // Undriven bus must not look like held data
        data_o <= (!as_n_i && read_write_i) ? rdata_i : ~data_o;
        if (as_n_i) begin
            wait_cnt <= 0;
            ack_n_o <= 1'b1;
            fault_n_o <= 1'b1;
            if (halt_cnt > 0) halt_cnt <= halt_cnt - 1;
            else halt_n_o <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
            // Never answers twice, so no fault follows an acknowledge
            if (wait_cnt >= delay_i && ack_n_o && fault_n_o && (read_write_i || !ds_n_i)) begin
                if (mode_i == 2'h1) fault_n_o <= 1'b0;
                else if (mode_i == 2'h2 && !retried) begin
                    fault_n_o <= 1'b0;
                    halt_n_o <= 1'b0;
                    halt_cnt <= 4;
                    retried <= 1'b1;
                end else begin
                    ack_n_o <= 1'b0;
                    if (!read_write_i) got_o <= wdata_i;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/test_handshake_bus_cycle_master.sv
// Bench for the bus cycle master: runs reads, writes, waits, fault and retry.
// Assumes hbm_slave_model stands on the bus side and answers per cycle settings.
`include "hbm_defs.svh"
`default_nettype none
module test_handshake_bus_cycle_master;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic req_i = 1'b0;
    logic wr = 1'b0;
    logic wd = 1'b0;
    logic [23:0] ad = '0;
    logic [2:0] fc = '0;
    logic [15:0] dv = '0;
    logic [7:0] dl = '0;
    logic [1:0] md = '0;
    logic ready_o, done_o, fault_o, addr_oe_o, read_write_o, as_n, ub_n, lb_n, data_oe;
    logic ack_n, fault_n, halt_n;
    logic [23:0] addr_o;
    logic [2:0] fc_o;
    logic [15:0] rdata_o, mdata, sdata, got;
    int error_cnt = 0;
    int n_checks = 0;
    int as_low, falls;
    logic ub_seen, lb_seen, rw_low, bad, saw_done, saw_fault, prev_as;

    always #12.5 clk_i = ~clk_i;

    hbm_master uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .req_write_i(wr),
        .req_word_i(wd), .req_addr_i(ad), .req_fc_i(fc), .req_wdata_i(dv),
        .ready_o(ready_o), .done_o(done_o), .fault_o(fault_o), .rdata_o(rdata_o),
        .addr_o(addr_o), .addr_oe_o(addr_oe_o), .fc_o(fc_o), .read_write_o(read_write_o),
        .address_strobe_n_o(as_n), .upper_byte_strobe_n_o(ub_n),
        .lower_byte_strobe_n_o(lb_n), .data_o(mdata), .data_oe_o(data_oe), .data_i(sdata),
        .transfer_ack_n_i(ack_n), .bus_fault_n_i(fault_n), .halt_n_i(halt_n));

    hbm_slave_model slave (.clk_i(clk_i), .as_n_i(as_n), .ds_n_i(ub_n & lb_n),
        .read_write_i(read_write_o), .wdata_i(mdata), .delay_i(dl), .mode_i(md),
        .rdata_i(dv), .data_o(sdata), .ack_n_o(ack_n), .fault_n_o(fault_n),
        .halt_n_o(halt_n), .got_o(got));

    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: flag got %b exp %b", $time, g, e);
        end
    endtask

    task chk16(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: data got %h exp %h", $time, g, e);
        end
    endtask

    // One bus cycle; the monitor runs until the done or fault pulse
    task run(input logic w, input logic b, input logic [23:0] a, input logic [15:0] v,
             input logic [7:0] d, input logic [1:0] m);
        {as_low, falls} = '0;
        {ub_seen, lb_seen, rw_low, bad, saw_done, saw_fault} = '0;
        prev_as = 1'b1;
        @(posedge clk_i);
        req_i <= 1'b1;
        {wr, wd, ad, fc, dv, dl, md} <= {w, b, a, {w, b, 1'b1}, v, d, m};
        @(posedge clk_i);
        req_i <= 1'b0;
        for (int i = 0; i < 400 && !(saw_done || saw_fault); i++) begin
            @(posedge clk_i);
            #1;
            if (as_n === 1'b0) begin
                as_low++;
                if (prev_as) falls++;
                if (fc_o !== {w, b, 1'b1} || addr_o !== a || addr_oe_o !== 1'b1) bad = 1;
                if (!w && ({ub_n, lb_n} !== ~{b | ~a[0], b | a[0]} || data_oe)) bad = 1;
                if (w && !(ub_n & lb_n) && (!data_oe || read_write_o || mdata !== v)) bad = 1;
                ub_seen |= !ub_n;
                lb_seen |= !lb_n;
                rw_low |= !read_write_o;
            end
            prev_as = as_n;
            saw_done = done_o === 1'b1;
            saw_fault = fault_o === 1'b1;
        end
        if (!(saw_done || saw_fault)) begin
            error_cnt++;
            report_and_stop;
        end
    endtask

    task judge(input int nf, input logic dn);
        chk1(bad, 1'b0);
        chk1(ub_seen, wd | ~ad[0]);
        chk1(lb_seen, wd | ad[0]);
        chk1(rw_low, wr);
        chk1(saw_done, dn);
        chk1(saw_fault, !dn);
        chk1(falls == nf, 1'b1);
        chk1(as_low % 2 == nf % 2 && as_low >= 5 * nf, 1'b1);
        chk1(as_n & ub_n & lb_n & read_write_o & !addr_oe_o & !data_oe, 1'b1);
    endtask

    task t_read_even;
        run(1'b0, 1'b0, 24'h000100, 16'ha5c3, 8'h00, 2'h0);
        judge(1, 1'b1);
        chk16(rdata_o, 16'ha5c3);
    endtask

    task t_read_word_wait;
        run(1'b0, 1'b1, 24'h000203, 16'h3c5a, 8'h07, 2'h0);
        judge(1, 1'b1);
        chk16(rdata_o, 16'h3c5a);
    endtask

    task t_write_odd;
        run(1'b1, 1'b0, 24'h0a0001, 16'h1234, 8'h00, 2'h0);
        judge(1, 1'b1);
        chk16(got, 16'h1234);
    endtask

    task t_write_long;
        run(1'b1, 1'b1, 24'h000ffe, 16'hbeef, 8'h28, 2'h0);
        judge(1, 1'b1);
        chk1(as_low >= 40, 1'b1);
        chk16(got, 16'hbeef);
    endtask

    task t_fault;
        run(1'b0, 1'b1, 24'h123456, 16'h0f0f, 8'h03, 2'h1);
        judge(1, 1'b0);
    endtask

    task t_retry;
        run(1'b1, 1'b0, 24'h000010, 16'h00c3, 8'h02, 2'h2);
        judge(2, 1'b1);
        chk16(got, 16'h00c3);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk1(ready_o & as_n & read_write_o, 1'b1);
        t_read_even();
        t_write_odd();
        t_read_word_wait();
        t_write_long();
        t_fault();
        t_retry();
        report_and_stop();
    end
endmodule
`default_nettype wire
